// File: board_clock_model.sv
// Purpose: board clock sources and strap pins beside the logic cells
// Assumes: pins are sampled by the block in the pclk domain
// Notes:   clock pins rest low outside pulses, never floating
`timescale 1ns/10ps
`default_nettype none

module board_clock_model (
    // clock
    input  wire logic pclk,
    // strap request
    input  wire logic ground_test_reset,
    // board pins
    output logic      hard_clock,
    output logic      routed_clock_first,
    output logic      routed_clock_second,
    output logic      test_reset
);
    // ****************************************
    // tie-offs
    // ****************************************
    // idle clock pins held at a fixed low level
    initial begin
        hard_clock          = 1'b0;
        routed_clock_first  = 1'b0;
        routed_clock_second = 1'b0;
    end

    // strap grounded on request, otherwise pulled high
    assign test_reset = !ground_test_reset;

    // ****************************************
    // one clock cycle on a pin
    // ****************************************
    // each level held at least seven pclk, well above the two-cycle minimum
    task automatic pulse(input int which);
        for (int lvl = 1; lvl >= 0; lvl--) begin
            @(posedge pclk);
            case (which)
                0: hard_clock <= lvl[0];
                1: routed_clock_first <= lvl[0];
                default: routed_clock_second <= lvl[0];
            endcase
            repeat (6) @(posedge pclk);
        end
    endtask
endmodule

`default_nettype wire

// File: comb_cell.sv
// Purpose: one combinational cell, five-input function by truth table
// Assumes: inputs already in the pclk domain
// Notes:   input 0 is the invertible input
`timescale 1ns/10ps
`default_nettype none

module comb_cell (
    // function
    input  wire logic [31:0] truth,
    input  wire logic        invert,
    // operands
    input  wire logic [4:0]  operand,
    // result
    output logic             result
);

    logic [4:0] index;

    always_comb begin
        index  = {operand[4:1], operand[0] ^ invert};
        result = truth[index];
    end

endmodule

`default_nettype wire

// File: logic_cell_defs.svh
// Purpose: offsets, field positions, reset values and counts of the
//          logic cell and clock network block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   definitions only
`ifndef LOGIC_CELL_DEFS_SVH
`define LOGIC_CELL_DEFS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define OFF_CTRL        12'h000
`define OFF_SEQ_CFG     12'h004
`define OFF_TT0         12'h008
`define OFF_TT1         12'h00C
`define OFF_INV         12'h010
`define OFF_PULL        12'h014
`define OFF_STATUS      12'h018

// ****************************************
// control fields
// ****************************************
`define CTRL_TRST_RSV   0
`define CTRL_FIRST_INT  1
`define CTRL_SECOND_INT 2
`define CTRL_MACRO_EN   3

// ****************************************
// per sequential cell config, one nibble each; pull-down field position
// ****************************************
`define SEQ_FIELD_W     4
`define SEQ_FALLING     0
`define SEQ_SEL_LO      1
`define PULL_DOWN_POS   8

// ****************************************
// reset values and counts
// ****************************************
`define RST_CTRL        32'h0000_0000
`define RST_SEQ_CFG     32'h0000_0000
`define RST_TT          32'h0000_0000
`define RST_PULL        32'h0000_0000
`define HCLK_HOLD_RISES 2'h2

`endif

// File: logic_cell_pkg.sv
// Purpose: types shared by the logic cell and clock network files
// Assumes: nothing
// Notes:   clock select codes live here; other constants live in logic_cell_defs.svh
package logic_cell_pkg;

    typedef logic [1:0] clk_sel_t;

    typedef enum logic [1:0] {
        HCLK_HOLD = 2'b01,
        HCLK_LIVE = 2'b10
    } hclk_state_e;

    localparam clk_sel_t SEL_HARD   = 2'h0;
    localparam clk_sel_t SEL_FIRST  = 2'h1;
    localparam clk_sel_t SEL_SECOND = 2'h2;

endpackage

// File: logic_cell_top.sv
// Purpose: sequential cells, combinational cells and the clock network
// Assumes: all pins asynchronous to pclk; config over APB
// Notes:   cell clocks are edges seen on sampled clock pins or, for internal drivers, on combinational cell outputs
//
// Contract
// - flop with clear, preset, enable from selects
// - per cell rising or falling edge choice
// - per cell clock mux: hard or routed
// - hard clock dead until fourth cycle; its third falling edge already reaches falling-edge cells
// - reserved grounded test reset skips hold
// - hard clock feeds sequential cells only
// - routed clocks from pin or internal driver
// - five-input function with invertible input
// - two combinational cells form a flop
// - outputs tristated until power is good
// - per output power-up pull up or down
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "logic_cell_defs.svh"

module logic_cell_top #(
    parameter int NUM_SEQ = 4
) (
    // clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // clock pins
    input  wire logic                 hard_clock,
    input  wire logic                 routed_clock_first,
    input  wire logic                 routed_clock_second,
    input  wire logic                 test_reset,
    input  wire logic                 power_good,
    // sequential cell pins
    input  wire logic [NUM_SEQ-1:0]   seq_d,
    input  wire logic [NUM_SEQ-1:0]   seq_clear,
    input  wire logic [NUM_SEQ-1:0]   seq_preset,
    input  wire logic [NUM_SEQ-1:0]   enable_select_line_zero,
    input  wire logic [NUM_SEQ-1:0]   enable_select_line_one,
    // combinational cell pins
    input  wire logic [9:0]           comb_in,
    output logic      [1:0]           comb_out,
    output logic                      macro_q,
    // output pads
    output logic      [NUM_SEQ-1:0]   pad_out,
    output logic      [NUM_SEQ-1:0]   pad_oe_n,
    output logic      [NUM_SEQ-1:0]   pad_pull_up,
    output logic      [NUM_SEQ-1:0]   pad_pull_down
);
    import logic_cell_pkg::*;

    localparam int RAW_W = 5 + 5 * NUM_SEQ + 10;

    // ****************************************
    // input synchronisers
    // ****************************************
    logic [RAW_W-1:0]   sync_meta;
    logic [RAW_W-1:0]   sync_out;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_meta <= '0;
            sync_out  <= '0;
        end else begin
            sync_meta <= {hard_clock, routed_clock_first,
                          routed_clock_second, test_reset, power_good,
                          seq_d, seq_clear, seq_preset,
                          enable_select_line_zero,
                          enable_select_line_one, comb_in};
            sync_out  <= sync_meta;
        end
    end

    logic               hclk_s;
    logic               first_pin_s;
    logic               second_pin_s;
    logic               trst_s;
    logic               power_ok;
    logic [NUM_SEQ-1:0] d_s;
    logic [NUM_SEQ-1:0] clr_s;
    logic [NUM_SEQ-1:0] pre_s;
    logic [NUM_SEQ-1:0] sel0_s;
    logic [NUM_SEQ-1:0] sel1_s;
    logic [9:0]         comb_in_s;

    assign {hclk_s, first_pin_s, second_pin_s, trst_s, power_ok,
            d_s, clr_s, pre_s, sel0_s, sel1_s, comb_in_s} = sync_out;

    // ****************************************
    // registers
    // ****************************************
    logic [31:0]        ctrl;
    logic [31:0]        seq_cfg;
    logic [31:0]        truth0;
    logic [31:0]        truth1;
    logic [1:0]         inv_cfg;
    logic [31:0]        pull_cfg;
    logic [31:0]        status;
    logic               wr_take;
    logic               access;

    assign access  = psel && penable && !pready;
    assign wr_take = psel && penable && pready && pwrite;

    function automatic logic addr_mapped(input logic [11:0] a);
        return a == `OFF_CTRL || a == `OFF_SEQ_CFG || a == `OFF_TT0 ||
               a == `OFF_TT1 || a == `OFF_INV || a == `OFF_PULL ||
               a == `OFF_STATUS;
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl     <= `RST_CTRL;
            seq_cfg  <= `RST_SEQ_CFG;
            truth0   <= `RST_TT;
            truth1   <= `RST_TT;
            inv_cfg  <= 2'h0;
            pull_cfg <= `RST_PULL;
        end else if (wr_take) begin
            unique case (paddr)
                `OFF_CTRL:    ctrl     <= pwdata;
                `OFF_SEQ_CFG: seq_cfg  <= pwdata;
                `OFF_TT0:     truth0   <= pwdata;
                `OFF_TT1:     truth1   <= pwdata;
                `OFF_INV:     inv_cfg  <= pwdata[1:0];
                `OFF_PULL:    pull_cfg <= pwdata;
                default:      ;
            endcase
        end
    end

    // one wait state: answer in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= access;
            pslverr <= access && !addr_mapped(paddr);
            if (access && !pwrite) begin
                unique case (paddr)
                    `OFF_CTRL:    prdata <= ctrl;
                    `OFF_SEQ_CFG: prdata <= seq_cfg;
                    `OFF_TT0:     prdata <= truth0;
                    `OFF_TT1:     prdata <= truth1;
                    `OFF_INV:     prdata <= {30'h0000_0000, inv_cfg};
                    `OFF_PULL:    prdata <= pull_cfg;
                    `OFF_STATUS:  prdata <= status;
                    default:      prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ****************************************
    // hard-wired clock start-up hold
    // ****************************************
    hclk_state_e        hclk_state;
    logic [1:0]         hclk_rises;
    logic               hclk_prev;
    logic               hclk_rise;
    logic               hclk_fall;
    logic               bypass;
    logic               hclk_gate;

    assign hclk_rise = hclk_s && !hclk_prev;
    assign hclk_fall = !hclk_s && hclk_prev;
    assign bypass    = ctrl[`CTRL_TRST_RSV] && !trst_s;
    assign hclk_gate = (hclk_state == HCLK_LIVE) || bypass;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hclk_prev <= 1'b0;
        end else begin
            hclk_prev <= hclk_s;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hclk_state <= HCLK_HOLD;
            hclk_rises <= 2'h0;
        end else begin
            unique case (hclk_state)
                HCLK_HOLD: begin
                    if (bypass) begin
                        hclk_state <= HCLK_LIVE;
                    end else if (hclk_rise) begin
                        if (hclk_rises == `HCLK_HOLD_RISES) begin
                            hclk_state <= HCLK_LIVE;
                        end
                        hclk_rises <= hclk_rises + 2'h1;
                    end
                end
                HCLK_LIVE: hclk_state <= HCLK_LIVE;
                default:   hclk_state <= HCLK_HOLD;
            endcase
        end
    end

    // ****************************************
    // routed clocks and combinational cells
    // ****************************************
    logic [1:0]         comb_y;
    logic               first_lvl;
    logic               second_lvl;
    logic               first_prev;
    logic               second_prev;

    generate
        for (genvar c = 0; c < 2; c++) begin : g_comb
            comb_cell u_cell (
                .truth   (c == 0 ? truth0 : truth1),
                .invert  (inv_cfg[c]),
                .operand (comb_in_s[5*c +: 5]),
                .result  (comb_y[c])
            );
        end
    endgenerate

    // internal clock driver takes a combinational cell output
    assign first_lvl  = ctrl[`CTRL_FIRST_INT]
                        ? comb_y[0] : first_pin_s;
    assign second_lvl = ctrl[`CTRL_SECOND_INT]
                        ? comb_y[1] : second_pin_s;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_prev  <= 1'b0;
            second_prev <= 1'b0;
            comb_out    <= 2'h0;
        end else begin
            first_prev  <= first_lvl;
            second_prev <= second_lvl;
            comb_out    <= comb_y;
        end
    end

    logic [1:0]         rises;
    logic [1:0]         falls;

    assign rises = {second_lvl && !second_prev, first_lvl && !first_prev};
    assign falls = {!second_lvl && second_prev, !first_lvl && first_prev};

    // paired-cell flop macro: cell 0 data, cell 1 load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            macro_q <= 1'b0;
        end else if (ctrl[`CTRL_MACRO_EN] && rises[0] && comb_y[1]) begin
            macro_q <= comb_y[0];
        end
    end

    // ****************************************
    // sequential cells
    // ****************************************
    function automatic logic cell_tick(input clk_sel_t sel,
                                       input logic falling,
                                       input logic hr, input logic hf,
                                       input logic [1:0] r,
                                       input logic [1:0] f);
        logic rise_ev;
        logic fall_ev;
        rise_ev = 1'b0;
        fall_ev = 1'b0;
        unique case (sel)
            SEL_HARD: begin
                rise_ev = hr;
                fall_ev = hf;
            end
            SEL_FIRST: begin
                rise_ev = r[0];
                fall_ev = f[0];
            end
            SEL_SECOND: begin
                rise_ev = r[1];
                fall_ev = f[1];
            end
            default: ;
        endcase
        return falling ? fall_ev : rise_ev;
    endfunction

    logic [NUM_SEQ-1:0] tick;
    logic [NUM_SEQ-1:0] load;

    generate
        for (genvar i = 0; i < NUM_SEQ; i++) begin : g_seq
            localparam int B = `SEQ_FIELD_W * i;

            assign tick[i] = cell_tick(
                seq_cfg[B+`SEQ_SEL_LO +: 2],
                seq_cfg[B+`SEQ_FALLING],
                hclk_rise && hclk_gate,
                hclk_fall && hclk_gate,
                rises, falls);
            assign load[i] = tick[i] &&
                             (sel0_s[i] || sel1_s[i]);

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pad_out[i] <= 1'b0;
                end else if (clr_s[i]) begin
                    pad_out[i] <= 1'b0;
                end else if (pre_s[i]) begin
                    pad_out[i] <= 1'b1;
                end else if (load[i]) begin
                    pad_out[i] <= d_s[i];
                end
            end

            AST_CLR_WINS: assert property (
                @(posedge pclk) disable iff (!presetn)
                clr_s[i] |=> !pad_out[i])
                else $error("clear did not force the cell low");
            AST_PRESET: assert property (
                @(posedge pclk) disable iff (!presetn)
                pre_s[i] && !clr_s[i] |=> pad_out[i])
                else $error("preset did not force the cell high");
            AST_HOLD: assert property (
                @(posedge pclk) disable iff (!presetn)
                !clr_s[i] && !pre_s[i] && !load[i]
                |=> $stable(pad_out[i]))
                else $error("cell changed without a clock edge");
        end
    endgenerate

    // ****************************************
    // output pads
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_oe_n      <= '1;
            pad_pull_up   <= '0;
            pad_pull_down <= '0;
        end else begin
            pad_oe_n      <= {NUM_SEQ{!power_ok}};
            pad_pull_up   <= power_ok ? '0
                             : pull_cfg[NUM_SEQ-1:0];
            pad_pull_down <= power_ok ? '0
                             : pull_cfg[`PULL_DOWN_POS +: NUM_SEQ]
                               & ~pull_cfg[NUM_SEQ-1:0];
        end
    end

    always_comb begin
        status        = 32'h0000_0000;
        status[0]     = hclk_state == HCLK_LIVE;
        status[2:1]   = hclk_rises;
        status[3]     = power_ok;
        status[4]     = macro_q;
        status[6:5]   = comb_out;
        status[8 +: NUM_SEQ] = pad_out;
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && !pready;
    endsequence

    AST_APB_ANSWER: assert property (
        s_setup ##1 s_access |=> pready ##1 !pready)
        else $error("apb answer not after one wait state");
    AST_APB_ERR: assert property (
        access && !addr_mapped(paddr) |=> pready && pslverr)
        else $error("unmapped address not flagged");
    AST_HCLK_HOLD: assert property (
        hclk_state == HCLK_HOLD && !bypass && hclk_rises != `HCLK_HOLD_RISES
        |-> !(hclk_rise && hclk_gate))
        else $error("hard clock edge passed during hold");
    AST_HCLK_LIVE: assert property (
        hclk_state == HCLK_HOLD && hclk_rise
        && hclk_rises == `HCLK_HOLD_RISES |=> hclk_state == HCLK_LIVE)
        else $error("hard clock not live at fourth cycle");
    AST_BYPASS: assert property (
        bypass |-> hclk_gate)
        else $error("grounded test reset did not bypass hold");
    AST_TRISTATE: assert property (
        !power_ok |=> pad_oe_n == '1)
        else $error("output driven before power good");
    AST_PULL: assert property (
        power_ok |=> pad_pull_up == '0 && pad_pull_down == '0)
        else $error("pull left on in operation");
    AST_COMB: assert property (
        1'b1 |=> comb_out == $past(comb_y))
        else $error("combinational output not registered");

endmodule

`default_nettype wire

// File: tb.sv
// Purpose: self-checking bench for the logic cell and clock network
// Assumes: APB answers with pready; pins pass two sync flops
// Notes:   cell 0 rising/first, 1 falling/first, 2 second, 3 hard
`timescale 1ns/10ps
`default_nettype none
`include "logic_cell_defs.svh"

module tb;
    import logic_cell_pkg::*;

    typedef struct packed {
        logic [31:0] tt;
        logic        inv;
        logic [4:0]  op;
        logic        res;
    } comb_row_s;

    localparam comb_row_s ROWS [7] = '{
        '{32'h0000_0001, 1'b0, 5'h00, 1'b1},
        '{32'h0000_0001, 1'b1, 5'h00, 1'b0},
        '{32'h8000_0000, 1'b0, 5'h1F, 1'b1},
        '{32'h8000_0000, 1'b1, 5'h1F, 1'b0},
        '{32'hAAAA_AAAA, 1'b0, 5'h01, 1'b1},
        '{32'h0000_0010, 1'b0, 5'h04, 1'b1},
        '{32'h0000_0010, 1'b1, 5'h05, 1'b1}
    };

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        err, power_good, ground_tr, macro_q;
    logic        hard_clock, routed_clock_first, routed_clock_second;
    logic        test_reset;
    logic [3:0]  seq_d, seq_clear, seq_preset, sel0, sel1;
    logic [3:0]  pad_out, pad_oe_n, pad_pull_up, pad_pull_down;
    logic [9:0]  comb_in;
    logic [1:0]  comb_out;
    int          err_count, samples_checked;

    logic_cell_top #(.NUM_SEQ(4)) u_logic_cell_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .hard_clock(hard_clock),
        .routed_clock_first(routed_clock_first),
        .routed_clock_second(routed_clock_second),
        .test_reset(test_reset), .power_good(power_good), .seq_d(seq_d),
        .seq_clear(seq_clear), .seq_preset(seq_preset),
        .enable_select_line_zero(sel0), .enable_select_line_one(sel1),
        .comb_in(comb_in), .comb_out(comb_out), .macro_q(macro_q),
        .pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down)
    );

    board_clock_model u_board_clock_model (
        .pclk(pclk), .ground_test_reset(ground_tr),
        .hard_clock(hard_clock), .routed_clock_first(routed_clock_first),
        .routed_clock_second(routed_clock_second), .test_reset(test_reset)
    );

    always #25 pclk = ~pclk;

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer, request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] addr,
                       input logic [31:0] data);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        @(posedge pclk);
        penable <= 1'b1;
        // pready, prdata and pslverr read as sampled at this edge
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) chk("pready", 32'h1, 32'h0);
    endtask

    task automatic rchk(input string what, input logic [11:0] addr,
                        input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        chk(what, exp, rd);
    endtask

    task automatic tally_and_finish();
        if (err_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        tally_and_finish();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
        pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
        power_good = 1'b0; ground_tr = 1'b0; comb_in = 10'h000;
        seq_d = 4'hF; seq_clear = 4'h0; seq_preset = 4'h0;
        sel0 = 4'hF; sel1 = 4'h0; err_count = 0; samples_checked = 0;
        repeat (8) @(posedge pclk);
        chk("oe_rst", 32'hF, pad_oe_n);
        chk("out_rst", 32'h0, pad_out);
        presetn <= 1'b1;
        rchk("ctrl", `OFF_CTRL, `RST_CTRL);
        rchk("seq_cfg", `OFF_SEQ_CFG, `RST_SEQ_CFG);
        rchk("tt0", `OFF_TT0, `RST_TT);
        rchk("pull", `OFF_PULL, `RST_PULL);
        rchk("unmapped", 12'h01C, 32'h0);
        chk("pslverr", 32'h1, err);
        apb(1'b1, `OFF_SEQ_CFG, 32'h0000_0432);
        rchk("seq_cfg", `OFF_SEQ_CFG, 32'h0000_0432);
        apb(1'b1, `OFF_PULL, 32'h0000_0201);
        repeat (2) @(posedge pclk);
        chk("pull_up", 32'h1, pad_pull_up);
        chk("pull_dn", 32'h2, pad_pull_down);
        chk("oe_pwr", 32'hF, pad_oe_n);
        for (int k = 1; k <= 4; k++) begin
            u_board_clock_model.pulse(0);
            chk("hard_hold", (k == 4) ? 32'h8 : 32'h0, pad_out);
        end
        power_good <= 1'b1;
        repeat (6) @(posedge pclk);
        chk("oe_run", 32'h0, pad_oe_n);
        foreach (ROWS[i]) begin
            apb(1'b1, `OFF_TT0, ROWS[i].tt);
            apb(1'b1, `OFF_TT1, ROWS[i].tt);
            apb(1'b1, `OFF_INV, {30'h0, ROWS[i].inv, ROWS[i].inv});
            comb_in <= {ROWS[i].op, ROWS[i].op};
            repeat (6) @(posedge pclk);
            chk("comb_out", {30'h0, {2{ROWS[i].res}}}, {30'h0, comb_out});
        end
        u_board_clock_model.pulse(1);
        chk("first_edges", 32'hB, pad_out);
        seq_d <= 4'h4;
        sel0  <= 4'hE;
        u_board_clock_model.pulse(1);
        chk("enable", 32'h9, pad_out);
        sel0 <= 4'h0;
        sel1 <= 4'hF;
        u_board_clock_model.pulse(2);
        chk("second", 32'hD, pad_out);
        seq_preset <= 4'h2;
        repeat (6) @(posedge pclk);
        chk("preset", 32'hF, pad_out);
        seq_clear <= 4'h3;
        repeat (6) @(posedge pclk);
        chk("clear_wins", 32'hC, pad_out);
        seq_clear  <= 4'h0;
        seq_preset <= 4'h0;
        // second reset: hold restarts, grounded strap skips it
        presetn   <= 1'b0;
        ground_tr <= 1'b1;
        seq_d     <= 4'hF;
        repeat (4) @(posedge pclk);
        chk("oe_rst2", 32'hF, pad_oe_n);
        presetn <= 1'b1;
        apb(1'b1, `OFF_CTRL, 32'h0000_0001);
        u_board_clock_model.pulse(0);
        chk("bypass", 32'hF, pad_out);
        // first routed clock taken from comb cell 0
        apb(1'b1, `OFF_SEQ_CFG, 32'h0000_0002);
        apb(1'b1, `OFF_TT0, 32'hAAAA_AAAA);
        apb(1'b1, `OFF_INV, 32'h0);
        comb_in <= 10'h000;
        apb(1'b1, `OFF_CTRL, 32'h0000_0003);
        seq_d   <= 4'h0;
        comb_in <= 10'h001;
        repeat (10) @(posedge pclk);
        chk("internal", 32'hE, pad_out);
        apb(1'b1, `OFF_TT1, 32'hFFFF_FFFF);
        apb(1'b1, `OFF_CTRL, 32'h0000_0009);
        u_board_clock_model.pulse(1);
        chk("macro", 32'h1, macro_q);
        tally_and_finish();
    end
endmodule

`default_nettype wire
